// ===== design/pmlt_phase_watch.sv
`include "pmlt_defs.svh"
`default_nettype none
// ----------------------------------------
// data phase watchdog
// ----------------------------------------
module pmlt_phase_watch
(
    input  wire logic       core_clk,   // pci clock
    input  wire logic       resetn,     // sync reset, low
    input  wire logic       active,     // a data phase is open
    input  wire logic       first,      // open phase is the first
    input  wire logic       done,       // phase completes this clock
    output var  logic       overrun     // phase exceeded its limit
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       ovr_q;
    logic       ovr_d;

    // count clocks of the open phase; restart on completion
    always_comb
    begin
        cnt_d = cnt_q;
        ovr_d = 1'b0;
        if (!active || done)
        begin
            cnt_d = 8'h00;
        end
        else
        begin
            if (cnt_q != 8'hff)
            begin
                cnt_d = cnt_q + 8'h01;
            end
            // first phase gets the longer allowance
            ovr_d = first ? (cnt_d >= `PMLT_FIRST_PHASE_MAX)
                          : (cnt_d >= `PMLT_NEXT_PHASE_MAX);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            cnt_q <= 8'h00;
            ovr_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            ovr_q <= ovr_d;
        end
    end

    assign overrun = ovr_q;
endmodule
`default_nettype wire

// ===== design/pmlt_top.sv
// Operation
// - load count-down with latency value on ownership
// - after zero, release on grant loss plus ready
// - grant held means burst without limit
// - first data phase done within 16 clocks
// - later data phases done within 8 clocks
// - next master granted one clock after release
// - tenure bounded by min(T+8, 16+8(n-1))
// - wait bounded by sum of T+8 per master
// - latency value cleared by pci reset
// - latency value steps of 8 clocks
// - limit counted from frame assertion, enforced
`include "pmlt_defs.svh"
`default_nettype none
module pmlt_top
(
    input  wire logic       core_clk,      // pci clock, 200 mhz
    input  wire logic       resetn,        // sync reset, low
    input  wire logic       lat_wr,        // config write strobe for latency
    input  wire logic [7:0] lat_wdata,     // latency value written
    input  wire logic       xfer_req,      // core has a burst to run
    input  wire logic       xfer_last,     // core marks final word
    input  wire logic       gnt_n_pin,     // bus grant, low active pin
    input  wire logic       trdy_n_pin,    // target ready, low active pin
    input  wire logic       irdy_n_pin,    // bus busy indication, low
    input  wire logic       frame_n_pin,   // bus frame seen, low
    output var  logic       req_n,         // bus request, low
    output var  logic       frame_n_o,     // frame drive value
    output var  logic       frame_n_oe_n,  // frame enable, low drives
    output var  logic       irdy_n_o,      // initiator ready value
    output var  logic       irdy_n_oe_n,   // irdy enable, low drives
    output var  logic       word_done,     // one word transferred, pulse
    output var  logic       own_bus,       // master owns the bus
    output var  logic [7:0] lat_value,     // programmed latency value
    output var  logic [7:0] lat_count,     // count-down now
    output var  logic       phase_overrun  // target too slow
);
    import pmlt_pkg::*;

    // count-down step that sticks at zero, so an expired timer never wraps
    function automatic logic [7:0] dec_sat(input logic [7:0] v);
        return (v == 8'h00) ? 8'h00 : v - 8'h01;
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            s1_q <= 4'hf;
            s2_q <= 4'hf;
        end
        else
        begin
            s1_q <= {gnt_n_pin, trdy_n_pin, irdy_n_pin, frame_n_pin};
            s2_q <= s1_q;
        end
    end
    logic gnt;
    logic trdy;
    logic bus_idle;
    assign gnt      = !s2_q[3];
    assign trdy     = !s2_q[2];
    assign bus_idle = s2_q[1] && s2_q[0];

    // ----------------------------------------
    // latency value register
    // ----------------------------------------
    logic [7:0] lat_q;
    logic [7:0] lat_d;
    // low bits forced zero: value only moves in steps of 8
    always_comb
    begin
        lat_d = lat_q;
        if (lat_wr)
        begin
            lat_d = {lat_wdata[7:`PMLT_LAT_GRAN_LSB], 3'h0};
        end
    end
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            lat_q <= `PMLT_LAT_RESET;
        end
        else
        begin
            lat_q <= lat_d;
        end
    end

    // ----------------------------------------
    // tenure state machine and count-down
    // ----------------------------------------
    pmlt_state_t st_q;
    pmlt_state_t st_d;
    logic [7:0]  cnt_q;
    logic [7:0]  cnt_d;
    logic        first_q;
    logic        first_d;
    logic        fin_q;
    logic        fin_d;
    logic        done_now;
    logic        expired;
    logic        last_phase;

    assign done_now = (st_q == PMLT_DATA) && trdy;
    assign expired  = (cnt_q == 8'h00);
    // final phase: core says so, or timer out with grant gone
    assign last_phase = xfer_last || fin_q || (expired && !gnt);

    always_comb
    begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        first_d = first_q;
        fin_d   = fin_q;
        case (st_q)
            PMLT_IDLE:
            begin
                // start only with grant on an idle bus
                if (xfer_req && gnt && bus_idle)
                begin
                    st_d    = PMLT_ADDR;
                    cnt_d   = lat_q;
                    first_d = 1'b1;
                    fin_d   = 1'b0;
                end
            end
            PMLT_ADDR:
            begin
                st_d  = PMLT_DATA;
                cnt_d = dec_sat(cnt_q);
            end
            PMLT_DATA:
            begin
                cnt_d = dec_sat(cnt_q);
                if (done_now)
                begin
                    first_d = 1'b0;
                    // leave on last word, or timer out with grant gone
                    if (last_phase)
                    begin
                        st_d = PMLT_TURN;
                    end
                end
                // timer out and grant gone: the open phase is final
                if (expired && !gnt)
                begin
                    fin_d = 1'b1;
                end
            end
            PMLT_TURN:
            begin
                st_d  = PMLT_IDLE;
                fin_d = 1'b0;
            end
            default:
            begin
                st_d = PMLT_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            st_q    <= PMLT_IDLE;
            cnt_q   <= 8'h00;
            first_q <= 1'b0;
            fin_q   <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            first_q <= first_d;
            fin_q   <= fin_d;
        end
    end

    // ----------------------------------------
    // phase watchdog
    // ----------------------------------------
    logic ovr;
    pmlt_phase_watch u_watch
    (
        .core_clk (core_clk),
        .resetn   (resetn),
        .active   (st_q == PMLT_DATA),
        .first    (first_q),
        .done     (done_now),
        .overrun  (ovr)
    );

    // ----------------------------------------
    // pin drive and status outputs
    // ----------------------------------------
    // frame drops on the final phase, as pci signalling expects
    logic frame_q;
    logic frame_d;
    logic irdy_q;
    logic irdy_d;
    logic drive_q;
    logic drive_d;
    logic wd_q;
    logic wd_d;
    always_comb
    begin
        frame_d = (st_d == PMLT_ADDR) || ((st_d == PMLT_DATA) && !(last_phase && st_q
                  == PMLT_DATA));
        irdy_d  = (st_d == PMLT_DATA);
        drive_d = (st_d == PMLT_ADDR) || (st_d == PMLT_DATA) || (st_d == PMLT_TURN);
        wd_d    = done_now;
    end
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            frame_q <= 1'b0;
            irdy_q  <= 1'b0;
            drive_q <= 1'b0;
            wd_q    <= 1'b0;
        end
        else
        begin
            frame_q <= frame_d;
            irdy_q  <= irdy_d;
            drive_q <= drive_d;
            wd_q    <= wd_d;
        end
    end

    // request held while work is pending and bus not yet won
    assign req_n         = !(xfer_req && (st_q == PMLT_IDLE));
    assign frame_n_o     = !frame_q;
    assign frame_n_oe_n  = !drive_q;
    assign irdy_n_o      = !irdy_q;
    assign irdy_n_oe_n   = !drive_q;
    assign word_done     = wd_q;
    assign own_bus       = (st_q != PMLT_IDLE);
    assign lat_value     = lat_q;
    assign lat_count     = cnt_q;
    assign phase_overrun = ovr;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    lat_load_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_q == PMLT_IDLE && st_d == PMLT_ADDR) |=> (cnt_q == $past(lat_q)))
        else $error("count not loaded on acquire");
    lat_gran_a: assert property (@(posedge core_clk) disable iff (!resetn)
        lat_q[2:0] == 3'h0)
        else $error("latency value off granularity");
    lat_reset_a: assert property (@(posedge core_clk)
        !resetn |=> lat_q == 8'h00)
        else $error("latency not cleared on reset");
    cnt_dec_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_q == PMLT_DATA && cnt_q != 8'h00) |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("count did not decrement");
    cnt_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_q == PMLT_DATA && cnt_q == 8'h00) |=> cnt_q == 8'h00)
        else $error("count left zero");
    burst_keep_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_q == PMLT_DATA && gnt && !fin_q && !xfer_last) |=> st_q == PMLT_DATA)
        else $error("left bus while granted");
    release_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (st_q == PMLT_DATA && cnt_q == 8'h00 && !gnt && trdy) |=> st_q == PMLT_TURN
        ##1 st_q == PMLT_IDLE)
        else $error("no release after expiry");
    turn_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
        st_q == PMLT_TURN |=> !own_bus && frame_n_oe_n)
        else $error("bus not freed after turnaround");
endmodule
`default_nettype wire

// ===== pkg/pmlt_defs.svh
`ifndef PMLT_DEFS_SVH
`define PMLT_DEFS_SVH

// latency value width and granularity
`define PMLT_LAT_W          8
`define PMLT_LAT_GRAN_LSB   3
`define PMLT_LAT_RESET      8'h00
// data phase limits in pci clocks
`define PMLT_FIRST_PHASE_MAX 8'h10
`define PMLT_NEXT_PHASE_MAX  8'h08
`define PMLT_TENURE_SLACK    8'h08

`endif

// ===== pkg/pmlt_pkg.sv
`default_nettype none
package pmlt_pkg;
    // bus tenure states, gray along idle->addr->data->release
    typedef enum logic [1:0]
    {
        PMLT_IDLE = 2'b00,
        PMLT_ADDR = 2'b01,
        PMLT_DATA = 2'b11,
        PMLT_TURN = 2'b10
    } pmlt_state_t;
endpackage
`default_nettype wire

// ===== testbench/pmlt_bus_model.sv
`default_nettype none
// ----------------------------------------
// arbiter and target stand-in
// ----------------------------------------
module pmlt_bus_model
(
    input  wire logic       core_clk,     // pci clock
    input  wire logic       resetn,       // sync reset, low
    input  wire logic       req_n,        // request from master
    input  wire logic       frame_n_o,    // master frame value
    input  wire logic       frame_n_oe_n, // frame enable, low drives
    input  wire logic       irdy_n_o,     // master irdy value
    input  wire logic       irdy_n_oe_n,  // irdy enable, low drives
    input  wire logic       gnt_en,       // arbiter keeps granting
    input  wire logic [4:0] trdy_wait,    // target wait states
    output var  logic       gnt_n_pin,    // grant to master
    output var  logic       trdy_n_pin,   // target ready
    output var  logic       frame_n_pin,  // resolved frame wire
    output var  logic       irdy_n_pin    // resolved irdy wire
);
    logic [4:0] wait_q;

    // pulled-up wires: a released line reads high, never the last value
    assign frame_n_pin = frame_n_oe_n | frame_n_o;
    assign irdy_n_pin  = irdy_n_oe_n | irdy_n_o;

    // grant one clock after request, held while the owner drives
    always_ff @(posedge core_clk)
    begin
        gnt_n_pin <= !(resetn && gnt_en && (!req_n || !frame_n_oe_n));
        if (!resetn || irdy_n_pin || !trdy_n_pin)
        begin
            wait_q     <= 5'h00;
            trdy_n_pin <= 1'b1;
        end
        else
        begin
            // one-clock ready after the chosen wait, per phase
            wait_q     <= wait_q + 5'h01;
            trdy_n_pin <= (wait_q != trdy_wait);
        end
    end
endmodule
`default_nettype wire

// ===== testbench/pmlt_top_tb.sv
`default_nettype none
module pmlt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed
    {
        logic [7:0] wd;
        logic [7:0] n;
        logic [4:0] w;
        logic       keep;
        logic       ovr;
    } pmlt_row_t;
    // latency, words, wait, keep grant, overrun expected
    pmlt_row_t  rows [6] = '{'{8'h0f, 8'h02, 5'h04, 1'b1, 1'b0},
                             '{8'h07, 8'h01, 5'h04, 1'b1, 1'b0},
                             '{8'h08, 8'h0c, 5'h04, 1'b1, 1'b0},
                             '{8'h2b, 8'h03, 5'h0a, 1'b1, 1'b1},
                             '{8'h10, 8'h01, 5'h14, 1'b1, 1'b1},
                             '{8'h08, 8'h00, 5'h04, 1'b0, 1'b0}};
    logic       core_clk, resetn, lat_wr, xfer_req, xfer_last, gnt_en, clr;
    logic [7:0] lat_wdata, lat_value, lat_count, t;
    logic [4:0] trdy_wait;
    logic       gnt_n, trdy_n, irdy_n, frame_n, req_n, fo, foe, io, ioe;
    logic       word_done, own_bus, phase_overrun, ovr, zs;
    int         num_errors, num_checks, words, ten, k, i;

    pmlt_top i_pmlt_top (.core_clk(core_clk), .resetn(resetn), .lat_wr(lat_wr),
        .lat_wdata(lat_wdata), .xfer_req(xfer_req), .xfer_last(xfer_last),
        .gnt_n_pin(gnt_n), .trdy_n_pin(trdy_n), .irdy_n_pin(irdy_n),
        .frame_n_pin(frame_n), .req_n(req_n), .frame_n_o(fo), .frame_n_oe_n(foe),
        .irdy_n_o(io), .irdy_n_oe_n(ioe), .word_done(word_done), .own_bus(own_bus),
        .lat_value(lat_value), .lat_count(lat_count), .phase_overrun(phase_overrun));
    pmlt_bus_model i_pmlt_bus_model (.core_clk(core_clk), .resetn(resetn), .req_n(req_n),
        .frame_n_o(fo), .frame_n_oe_n(foe), .irdy_n_o(io), .irdy_n_oe_n(ioe),
        .gnt_en(gnt_en), .trdy_wait(trdy_wait), .gnt_n_pin(gnt_n), .trdy_n_pin(trdy_n),
        .frame_n_pin(frame_n), .irdy_n_pin(irdy_n));

    // ----------------------------------------
    // clock, watchdog and tenure monitor
    // ----------------------------------------
    initial
    begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ceiling well above six bursts of under a hundred clocks each
    initial
    begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        report_and_stop();
    end
    always @(posedge core_clk)
        if (clr)
        begin
            words <= 0;
            ten   <= 0;
            ovr   <= 0;
            zs    <= 0;
        end
        else
        begin
            words <= words + int'(word_done);
            ten   <= ten + int'(own_bus);
            ovr   <= ovr | phase_overrun;
            zs    <= zs | (own_bus && lat_count == 8'h00);
        end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    // one tenure: program, request, burst, release
    task automatic run(input pmlt_row_t r);
        t = r.wd & 8'hf8;
        lat_wr = 1;
        lat_wdata = r.wd;
        gnt_en = 1;
        trdy_wait = r.w;
        clr = 1;
        step(1);
        lat_wr = 0;
        clr = 0;
        check(lat_value, t);
        xfer_req = 1;
        for (k = 0; k < 40 && own_bus !== 1'b1; k++)
            step(1);
        check(own_bus, 8'h01);
        check(k <= int'(t) + 8, 8'h01);
        check(fo, 8'h00);
        check(lat_count, t);
        step(1);
        check(io, 8'h00);
        check(lat_count, (t == 8'h00) ? 8'h00 : t - 8'h01);
        gnt_en = r.keep;
        for (k = 0; k < 600 && own_bus === 1'b1; k++)
        begin
            xfer_last = (r.n != 0) && (words >= int'(r.n) - 1);
            step(1);
        end
        xfer_req = 0;
        xfer_last = 0;
        check(own_bus, 8'h00);
        check(ovr, r.ovr);
        if (r.n != 0)
            check(8'(words), r.n);
        else
            check(ten <= int'(t) + 8, 8'h01);
        step(2);
        check(foe, 8'h01);
        check(ioe, 8'h01);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {resetn, lat_wr, xfer_req, xfer_last, gnt_en, clr} = 6'b000011;
        lat_wdata = 8'h00;
        trdy_wait = 5'h04;
        num_errors = 0;
        num_checks = 0;
        step(12);
        check(lat_value, 8'h00);
        check(lat_count, 8'h00);
        resetn = 1;
        step(3);
        // tenures in turn, grant one clock after each request
        for (i = 0; i < 6; i++)
        begin
            run(rows[i]);
            if (i == 2)
                check(zs, 8'h01);
        end
        // reset in mid-tenure drops the bus and the value
        lat_wr = 1;
        lat_wdata = 8'h30;
        gnt_en = 1;
        step(1);
        lat_wr = 0;
        xfer_req = 1;
        step(6);
        check(own_bus, 8'h01);
        check(lat_count, 8'h2e);
        resetn = 0;
        step(2);
        check(lat_value, 8'h00);
        check(own_bus, 8'h00);
        check(lat_count, 8'h00);
        xfer_req = 0;
        resetn = 1;
        step(3);
        report_and_stop();
    end
endmodule
`default_nettype wire
